//--- core/sksp_defs.svh
// Register offsets, reset values and field positions for the segment key scan port registers
`ifndef SKSP_DEFS_SVH
`define SKSP_DEFS_SVH
// ==========================================
// Register addresses (CPU memory bus, byte)
`define SKSP_ADDR_GROUP_A 16'hFF0E
`define SKSP_ADDR_GROUP_B 16'hFF0F
`define SKSP_ADDR_P4_DIR 16'hFF24
`define SKSP_ADDR_P1_PU 16'hFF31
`define SKSP_ADDR_P4_PU 16'hFF34
// ==========================================
// Reset values
`define SKSP_RST_GROUP 8'h00
`define SKSP_RST_P4_DIR 8'hFF
`define SKSP_RST_PU 8'h00
// ==========================================
// Field positions
`define SKSP_FIRST_LSB 0
`define SKSP_LATTER_LSB 4
`define SKSP_KEY_SCAN_EN_BIT 0
`endif

//--- core/sksp_pkg.sv
// Types shared by the segment key scan port register block
package sksp_pkg;
	typedef logic [7:0] sksp_byte_t;
	typedef enum logic [2:0] {
		SKSP_SEL_NONE,
		SKSP_SEL_GROUP_A,
		SKSP_SEL_GROUP_B,
		SKSP_SEL_P4_DIR,
		SKSP_SEL_P1_PU,
		SKSP_SEL_P4_PU
	} sksp_sel_e;
endpackage

//--- core/sksp_scan_mux.sv
// Per-output half-period level selection for the key scan outputs
`timescale 1ns/10ps
module sksp_scan_mux
	import sksp_pkg::*;
#(
	parameter int NOUT = 8
) (
	input wire logic [NOUT-1:0] first_i, // First-half levels
	input wire logic [NOUT-1:0] latter_i, // Latter-half levels
	input wire logic latter_half_i, // High in latter half of the period
	output logic [NOUT-1:0] level_o // Selected level per output
);
	// ==========================================
	// Selection
	genvar g;
	generate
		for (g = 0; g < NOUT; g++) begin : g_sel
			// Both bits of a pair steer one output
			assign level_o[g] = latter_half_i ? latter_i[g] : first_i[g];
		end
	endgenerate
endmodule

//--- core/sksp_regs.sv
// Segment key scan port registers: direction, pull-up options and scan output levels
// Function
// - Direction bit 0 output, 1 input
// - Direction at FF24H, reset FFH, unimplemented read 1
// - Port-1 pull-up option resets to 00H
// - Scan pin option 0: pull-up during scan period
// - Non-scan pin: 0 no pull-up, 1 pull-up
// - Port-4 pull-up same meaning, resets 00H
// - Group A bits 0-3 first half, outputs 0-3
// - Group A bits 4-7 latter half, 0 low
// - Group A at FF0EH, reset 00H
// - Group B bits 0-3 first half, outputs 4-7
// - Group B bits 4-7 latter half levels
// - Group B at FF0FH, reset 00H
// - Bit and byte writes; bit write touches one
// - Scan pin driven by its first/latter pair
// - Key scan enabled by LCD mode bit 0
`timescale 1ns/10ps
`include "sksp_defs.svh"
module sksp_regs
	import sksp_pkg::*;
#(
	parameter logic [7:0] P4_IMPL_MASK = 8'hFF, // Implemented port-4 direction bits
	parameter logic [7:0] P1_IMPL_MASK = 8'h0E // Implemented port-1 pull-up bits
) (
	input wire logic ref_clk_i, // System clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic [15:0] addr_i, // CPU address
	input wire logic wr_i, // Byte write strobe
	input wire logic bit_wr_i, // Single-bit write strobe
	input wire logic [2:0] bit_sel_i, // Bit number for bit write
	input wire logic bit_val_i, // Bit value for bit write
	input wire logic [7:0] wdata_i, // Byte write data
	input wire logic rd_i, // Read strobe
	input wire logic [7:0] lcd_mode_reg_i, // LCD mode register value
	input wire logic scan_period_i, // Scan output period active
	input wire logic latter_half_i, // Latter half of scan period
	input wire logic [7:0] p1_scan_in_i, // Port-1 pins used as key scan inputs
	input wire logic [7:0] p4_scan_in_i, // Port-4 pins used as key scan inputs
	output logic [7:0] rdata_o, // Read data
	output logic rvalid_o, // Read data valid
	output logic [7:0] p4_oe_o, // Port-4 output buffer enable
	output logic [7:0] p1_pullup_o, // Port-1 pull-up connect
	output logic [7:0] p4_pullup_o, // Port-4 pull-up connect
	output logic [7:0] scan_out_o, // Key scan output levels
	output logic key_scan_enable_o, // Key scan mode active
	output logic [7:0] group_a_o, // Group A for ordinary port use
	output logic [7:0] group_b_o // Group B for ordinary port use
);
	// ==========================================
	// State
	typedef struct packed {
		logic [7:0] group_a;
		logic [7:0] group_b;
		logic [7:0] p4_dir;
		logic [7:0] p1_pu;
		logic [7:0] p4_pu;
		logic [7:0] rdata;
		logic rvalid;
		logic [7:0] p4_oe;
		logic [7:0] p1_pull;
		logic [7:0] p4_pull;
		logic [7:0] scan;
		logic ks_en;
	} sksp_state_s;

	sksp_state_s st_r;
	sksp_state_s st_nxt;
	logic [7:0] level_w;
	logic key_scan_enable;

	// Address decode, shared by read and write paths
	function automatic sksp_sel_e sksp_decode(input logic [15:0] a);
		unique case (a)
			`SKSP_ADDR_GROUP_A: sksp_decode = SKSP_SEL_GROUP_A;
			`SKSP_ADDR_GROUP_B: sksp_decode = SKSP_SEL_GROUP_B;
			`SKSP_ADDR_P4_DIR: sksp_decode = SKSP_SEL_P4_DIR;
			`SKSP_ADDR_P1_PU: sksp_decode = SKSP_SEL_P1_PU;
			`SKSP_ADDR_P4_PU: sksp_decode = SKSP_SEL_P4_PU;
			default: sksp_decode = SKSP_SEL_NONE;
		endcase
	endfunction

	// Merge one write into a byte: a bit write touches only its bit
	function automatic logic [7:0] sksp_merge(input logic [7:0] old, input logic byte_w, input logic bit_w,
		input logic [2:0] bsel, input logic bval, input logic [7:0] wd);
		logic [7:0] v;
		v = old;
		if (byte_w) begin
			v = wd;
		end else if (bit_w) begin
			v[bsel] = bval;
		end
		sksp_merge = v;
	endfunction

	// Pull-up decision: scan pins pull up only during the period
	function automatic logic [7:0] sksp_pull(input logic [7:0] pu, input logic [7:0] scan_pin, input logic en,
		input logic period);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (en && scan_pin[i]) begin
				v[i] = ~pu[i] & period;
			end else begin
				v[i] = pu[i];
			end
		end
		sksp_pull = v;
	endfunction

	assign key_scan_enable = lcd_mode_reg_i[`SKSP_KEY_SCAN_EN_BIT];

	// Each scan output takes its first-half or latter-half bit
	sksp_scan_mux #(
		.NOUT(8)
	) u_mux (
		.first_i({st_r.group_b[3:0], st_r.group_a[3:0]}),
		.latter_i({st_r.group_b[7:4], st_r.group_a[7:4]}),
		.latter_half_i(latter_half_i),
		.level_o(level_w)
	);

	// ==========================================
	// Next-state logic
	always_comb begin
		sksp_sel_e sel;
		logic do_w;
		sel = sksp_decode(addr_i);
		do_w = wr_i | bit_wr_i;
		st_nxt = st_r;
		if (do_w) begin
			unique case (sel)
				SKSP_SEL_GROUP_A: st_nxt.group_a = sksp_merge(st_r.group_a, wr_i, bit_wr_i, bit_sel_i, bit_val_i,
					wdata_i);
				SKSP_SEL_GROUP_B: st_nxt.group_b = sksp_merge(st_r.group_b, wr_i, bit_wr_i, bit_sel_i, bit_val_i,
					wdata_i);
				// Unimplemented direction bits stay 1
				SKSP_SEL_P4_DIR: st_nxt.p4_dir = sksp_merge(st_r.p4_dir, wr_i, bit_wr_i, bit_sel_i, bit_val_i,
					wdata_i) | ~P4_IMPL_MASK;
				SKSP_SEL_P1_PU: st_nxt.p1_pu = sksp_merge(st_r.p1_pu, wr_i, bit_wr_i, bit_sel_i, bit_val_i,
					wdata_i) & P1_IMPL_MASK;
				SKSP_SEL_P4_PU: st_nxt.p4_pu = sksp_merge(st_r.p4_pu, wr_i, bit_wr_i, bit_sel_i, bit_val_i,
					wdata_i);
				SKSP_SEL_NONE: ;
			endcase
		end
		// Unmapped reads return zero
		st_nxt.rvalid = rd_i;
		unique case (sel)
			SKSP_SEL_GROUP_A: st_nxt.rdata = st_r.group_a;
			SKSP_SEL_GROUP_B: st_nxt.rdata = st_r.group_b;
			SKSP_SEL_P4_DIR: st_nxt.rdata = st_r.p4_dir;
			SKSP_SEL_P1_PU: st_nxt.rdata = st_r.p1_pu;
			SKSP_SEL_P4_PU: st_nxt.rdata = st_r.p4_pu;
			SKSP_SEL_NONE: st_nxt.rdata = 8'h00;
		endcase
		if (!rd_i) begin
			st_nxt.rdata = 8'h00;
		end
		// Outputs follow registered state and inputs, one cycle behind
		st_nxt.p4_oe = ~st_r.p4_dir;
		st_nxt.ks_en = key_scan_enable;
		st_nxt.p1_pull = sksp_pull(st_r.p1_pu, p1_scan_in_i & P1_IMPL_MASK, key_scan_enable, scan_period_i);
		st_nxt.p4_pull = sksp_pull(st_r.p4_pu, p4_scan_in_i, key_scan_enable, scan_period_i);
		// Outputs parked low outside key scan mode
		st_nxt.scan = key_scan_enable ? level_w : 8'h00;
	end

	// ==========================================
	// State register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
			st_r.group_a <= `SKSP_RST_GROUP;
			st_r.group_b <= `SKSP_RST_GROUP;
			st_r.p4_dir <= `SKSP_RST_P4_DIR;
			st_r.p1_pu <= `SKSP_RST_PU;
			st_r.p4_pu <= `SKSP_RST_PU;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o = st_r.rdata;
	assign rvalid_o = st_r.rvalid;
	assign p4_oe_o = st_r.p4_oe;
	assign p1_pullup_o = st_r.p1_pull;
	assign p4_pullup_o = st_r.p4_pull;
	assign scan_out_o = st_r.scan;
	assign key_scan_enable_o = st_r.ks_en;
	assign group_a_o = st_r.group_a;
	assign group_b_o = st_r.group_b;

	// ==========================================
	// Checks on reset values
	// At the first edge after release the state still holds its reset image
	a_dir_reset_val: assert property (@(posedge ref_clk_i)
		$rose(rst_n_i) |-> st_r.p4_dir == `SKSP_RST_P4_DIR)
		else $error("direction reset value wrong");
	a_p1_pu_reset: assert property (@(posedge ref_clk_i)
		$rose(rst_n_i) |-> st_r.p1_pu == `SKSP_RST_PU)
		else $error("port-1 pull-up reset value wrong");
	a_p4_pu_reset: assert property (@(posedge ref_clk_i)
		$rose(rst_n_i) |-> st_r.p4_pu == `SKSP_RST_PU)
		else $error("port-4 pull-up reset value wrong");
	a_group_a_reset: assert property (@(posedge ref_clk_i)
		$rose(rst_n_i) |-> st_r.group_a == `SKSP_RST_GROUP)
		else $error("group A reset value wrong");
	a_group_b_reset: assert property (@(posedge ref_clk_i)
		$rose(rst_n_i) |-> st_r.group_b == `SKSP_RST_GROUP)
		else $error("group B reset value wrong");
	// Unimplemented bits never reach the stored value, whatever software writes
	a_dir_impl_ones: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(st_r.p4_dir | P4_IMPL_MASK) == 8'hFF)
		else $error("unimplemented direction bit not one");
	a_p1_impl_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(st_r.p1_pu & ~P1_IMPL_MASK) == 8'h00)
		else $error("unimplemented port-1 pull-up bit set");
	// ==========================================
	// Checks on register writes
	a_group_a_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_i && addr_i == `SKSP_ADDR_GROUP_A |=> st_r.group_a == $past(wdata_i))
		else $error("group A byte write lost");
	a_group_b_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_i && addr_i == `SKSP_ADDR_GROUP_B |=> st_r.group_b == $past(wdata_i))
		else $error("group B byte write lost");
	a_dir_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_i && addr_i == `SKSP_ADDR_P4_DIR |=> st_r.p4_dir == ($past(wdata_i) | ~P4_IMPL_MASK))
		else $error("direction byte write lost");
	a_p1_pu_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_i && addr_i == `SKSP_ADDR_P1_PU |=> st_r.p1_pu == ($past(wdata_i) & P1_IMPL_MASK))
		else $error("port-1 pull-up byte write lost");
	a_p4_pu_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_i && addr_i == `SKSP_ADDR_P4_PU |=> st_r.p4_pu == $past(wdata_i))
		else $error("port-4 pull-up byte write lost");
	a_bit_write_one: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		bit_wr_i && !wr_i && addr_i == 16'hFF0E |=>
		(st_r.group_a ^ $past(st_r.group_a)) == ((st_r.group_a[$past(bit_sel_i)] ^ $past(st_r.group_a[bit_sel_i]))
		<< $past(bit_sel_i)))
		else $error("bit write changed another bit");
	a_dir_bit_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		bit_wr_i && !wr_i && addr_i == `SKSP_ADDR_P4_DIR |=>
		st_r.p4_dir[$past(bit_sel_i)] == ($past(bit_val_i) | !P4_IMPL_MASK[$past(bit_sel_i)]))
		else $error("direction bit write wrong");
	a_idle_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!wr_i && !bit_wr_i |=> $stable(st_r.group_a) && $stable(st_r.group_b) && $stable(st_r.p4_dir))
		else $error("register changed without a write");
	// ==========================================
	// Checks on reads
	a_read_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		1'b1 |=> rvalid_o == $past(rd_i))
		else $error("read valid not one cycle after strobe");
	a_read_dir: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == `SKSP_ADDR_P4_DIR |=> rdata_o == $past(st_r.p4_dir))
		else $error("direction read wrong");
	a_read_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!rd_i |=> rdata_o == 8'h00)
		else $error("read data not parked at zero");
	// ==========================================
	// Checks on drive and scan outputs; every output trails the state and inputs by one cycle
	a_dir_oe_inv: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		##1 p4_oe_o == ~$past(st_r.p4_dir))
		else $error("output enable not inverse of direction");
	a_ks_en_copy: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		1'b1 |=> key_scan_enable_o == $past(lcd_mode_reg_i[`SKSP_KEY_SCAN_EN_BIT]))
		else $error("key scan enable copy wrong");
	a_scan_off_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!key_scan_enable |=> scan_out_o == 8'h00)
		else $error("scan outputs not low outside key scan");
	a_scan_first_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		key_scan_enable && !latter_half_i |=> scan_out_o[3:0] == $past(st_r.group_a[3:0]))
		else $error("group A first-half level wrong");
	a_scan_latter: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		key_scan_enable && latter_half_i |=> scan_out_o[3:0] == $past(st_r.group_a[7:4]))
		else $error("latter-half level wrong");
	a_scan_first: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		key_scan_enable && !latter_half_i |=> scan_out_o[7:4] == $past(st_r.group_b[3:0]))
		else $error("first-half level wrong");
	a_scan_latter_b: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		key_scan_enable && latter_half_i |=> scan_out_o[7:4] == $past(st_r.group_b[7:4]))
		else $error("group B latter-half level wrong");
	// ==========================================
	// Checks on pull-ups
	a_pull_on_scan: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		key_scan_enable && p4_scan_in_i[0] && scan_period_i && !st_r.p4_pu[0] |=> p4_pullup_o[0])
		else $error("scan pull-up missing in period");
	a_pull_period: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		key_scan_enable && p4_scan_in_i[0] && !scan_period_i |=> !p4_pullup_o[0])
		else $error("scan pull-up outside period");
	a_pull_bad_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		key_scan_enable && p4_scan_in_i[0] && st_r.p4_pu[0] |=> !p4_pullup_o[0])
		else $error("prohibited setting pulled up");
	a_pull_free: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		key_scan_enable && !p4_scan_in_i[0] |=> p4_pullup_o[0] == $past(st_r.p4_pu[0]))
		else $error("non-scan pull-up wrong");
	a_pull_plain: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!key_scan_enable |=> p4_pullup_o == $past(st_r.p4_pu))
		else $error("plain pull-up wrong");
	a_p1_plain: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!key_scan_enable |=> p1_pullup_o == $past(st_r.p1_pu))
		else $error("port-1 plain pull-up wrong");
	a_p1_period: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		key_scan_enable && p1_scan_in_i[1] && !scan_period_i |=> !p1_pullup_o[1])
		else $error("port-1 scan pull-up outside period");
endmodule

//--- verif/sksp_key_matrix.sv
// Key matrix model: diagonal keys joining scan outputs to return lines
`timescale 1ns/10ps
module sksp_key_matrix (
	input wire logic clk_i, // Sampling clock
	input wire logic [7:0] scan_i, // Scan output levels
	input wire logic [7:0] pull_i, // Pull-up connected
	input wire logic [7:0] press_i, // Pressed keys
	output logic [7:0] ret_o // Return line levels
);
	logic [7:0] last_r = 8'h00;
	// An unpulled line floats, so it shows the inverse of its last level rather than a stale one
	always @(posedge clk_i) last_r <= ret_o;
	// On a pulled-up line a pressed key pulls its return line to the scan level
	always_comb begin
		for (int j = 0; j < 8; j++) begin
			ret_o[j] = pull_i[j] ? (press_i[j] ? scan_i[j] : 1'b1) : ~last_r[j];
		end
	end
endmodule

//--- verif/segment_key_scan_port_regs_tb_top.sv
// Self-checking bench for the segment key scan port registers
`timescale 1ns/10ps
`include "sksp_defs.svh"
module segment_key_scan_port_regs_tb_top;
	import sksp_pkg::*;
	localparam logic [7:0] P4M = 8'h1F; // Narrow port 4 so forced-one direction bits are exercised
	localparam logic [7:0] P1M = 8'h0E;
	logic ref_clk_i, rst_n_i, wr_i, bit_wr_i, bit_val_i, rd_i, scan_period_i, latter_half_i, rvalid_o, key_scan_enable_o;
	logic [15:0] addr_i;
	logic [2:0] bit_sel_i;
	logic [7:0] wdata_i, lcd_mode_reg_i, p1_scan_in_i, p4_scan_in_i, rdata_o, p4_oe_o, p1_pullup_o, p4_pullup_o;
	logic [7:0] scan_out_o, group_a_o, group_b_o, key_ret, press, d, es, e1, e4;
	logic [7:0] exp_q[$];
	logic [7:0] sh[5];
	logic [15:0] at[5];
	logic [31:0] seed = 32'hC7AA2146;
	int n_errors = 0;
	int n_checks = 0;
	sksp_regs #(.P4_IMPL_MASK(P4M), .P1_IMPL_MASK(P1M)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.addr_i(addr_i), .wr_i(wr_i), .bit_wr_i(bit_wr_i), .bit_sel_i(bit_sel_i), .bit_val_i(bit_val_i),
		.wdata_i(wdata_i), .rd_i(rd_i), .lcd_mode_reg_i(lcd_mode_reg_i), .scan_period_i(scan_period_i),
		.latter_half_i(latter_half_i), .p1_scan_in_i(p1_scan_in_i), .p4_scan_in_i(p4_scan_in_i),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .p4_oe_o(p4_oe_o), .p1_pullup_o(p1_pullup_o),
		.p4_pullup_o(p4_pullup_o), .scan_out_o(scan_out_o), .key_scan_enable_o(key_scan_enable_o),
		.group_a_o(group_a_o), .group_b_o(group_b_o));
	sksp_key_matrix keys (.clk_i(ref_clk_i), .scan_i(scan_out_o), .pull_i(p4_pullup_o), .press_i(press),
		.ret_o(key_ret));
	// Xorshift source, fixed start so runs repeat
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Stored value: missing direction bits read 1, missing port-1 pull-up bits read 0
	function automatic logic [7:0] fit(int i, logic [7:0] v);
		return (i == 2) ? (v | ~P4M) : ((i == 3) ? (v & P1M) : v);
	endfunction
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One bus cycle; every strobe is set once per falling edge, so back-to-back calls never race
	task automatic cyc(input logic w, input logic bw, input logic r, input logic [15:0] a, input logic [7:0] v,
		input logic [2:0] bs, input logic bv);
		@(negedge ref_clk_i);
		{wr_i, bit_wr_i, rd_i, addr_i, wdata_i, bit_sel_i, bit_val_i} = {w, bw, r, a, v, bs, bv};
	endtask
	task automatic idle(input int n);
		repeat (n) cyc(1'b0, 1'b0, 1'b0, 16'h0000, 8'h00, 3'h0, 1'b0);
	endtask
	task automatic rdq(input int i);
		exp_q.push_back(sh[i]);
		cyc(1'b0, 1'b0, 1'b1, at[i], 8'h00, 3'h0, 1'b0);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Clock, 8 ns period
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	// Read results are matched against the oldest note at the falling edge, where they have settled
	always @(negedge ref_clk_i) begin
		if (rvalid_o === 1'b1) begin
			chk("rdata", rdata_o, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
		end
	end
	// Hang guard, well beyond the roughly 120 cycles the tests need
	initial begin
		#200000;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		{rst_n_i, wr_i, bit_wr_i, rd_i, bit_val_i, scan_period_i, latter_half_i} = '0;
		{addr_i, bit_sel_i, wdata_i, lcd_mode_reg_i, p1_scan_in_i, p4_scan_in_i, press} = '0;
		at = '{`SKSP_ADDR_GROUP_A, `SKSP_ADDR_GROUP_B, `SKSP_ADDR_P4_DIR, `SKSP_ADDR_P1_PU, `SKSP_ADDR_P4_PU};
		sh = '{`SKSP_RST_GROUP, `SKSP_RST_GROUP, `SKSP_RST_P4_DIR, `SKSP_RST_PU, `SKSP_RST_PU};
		repeat (8) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		idle(2);
		chk("p4_oe", p4_oe_o, 8'h00);
		for (int i = 0; i < 5; i++) rdq(i);
		exp_q.push_back(8'h00);
		cyc(1'b0, 1'b0, 1'b1, 16'hFF10, 8'h00, 3'h0, 1'b0);
		idle(3);
		$display("test reset values done");
		// Back-to-back byte writes, an unmapped write, then bit writes and a byte-beats-bit clash
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 5; i++) begin
				d = rnd();
				cyc(1'b1, 1'b0, 1'b0, at[i], d, 3'h0, 1'b0);
				sh[i] = fit(i, d);
			end
			cyc(1'b1, 1'b0, 1'b0, 16'hFF25, rnd(), 3'h0, 1'b0);
			for (int i = 0; i < 5; i++) rdq(i);
			for (int i = 0; i < 5; i++) begin
				d = rnd();
				cyc(1'b0, 1'b1, 1'b0, at[i], 8'h00, d[2:0], d[7]);
				sh[i][d[2:0]] = d[7];
				sh[i] = fit(i, sh[i]);
				rdq(i);
			end
			d = rnd();
			cyc(1'b1, 1'b1, 1'b0, at[0], d, 3'h1, ~d[1]);
			sh[0] = d;
			idle(1);
			chk("group_a", group_a_o, sh[0]);
			chk("group_b", group_b_o, sh[1]);
			idle(2);
			chk("p4_oe", p4_oe_o, ~sh[2]);
		end
		idle(3);
		$display("test register access done");
		// Every mix of enable, half and scan period; scan inputs keep their pull-up bits clear
		for (int m = 0; m < 8; m++) begin
			d = rnd();
			lcd_mode_reg_i = {d[7:1], m[0]};
			latter_half_i = m[1];
			scan_period_i = m[2];
			p1_scan_in_i = rnd() & P1M & ~sh[3];
			p4_scan_in_i = rnd() & ~sh[4];
			press = rnd();
			idle(3);
			es = m[1] ? {sh[1][7:4], sh[0][7:4]} : {sh[1][3:0], sh[0][3:0]};
			es = m[0] ? es : 8'h00;
			e1 = m[0] ? ((~sh[3] & {8{m[2]}} & p1_scan_in_i) | (sh[3] & ~p1_scan_in_i)) : sh[3];
			e4 = m[0] ? ((~sh[4] & {8{m[2]}} & p4_scan_in_i) | (sh[4] & ~p4_scan_in_i)) : sh[4];
			chk("key_scan_en", {7'h00, key_scan_enable_o}, {7'h00, m[0]});
			chk("scan_out", scan_out_o, es);
			chk("p1_pullup", p1_pullup_o, e1);
			chk("p4_pullup", p4_pullup_o, e4);
			chk("key_ret", key_ret & e4, ((press & es) | ~press) & e4);
		end
		$display("test scan and pull-up done");
		chk("reads_left", 8'(exp_q.size()), 8'h00);
		tally_and_finish();
	end
endmodule
